/* File: inc/scb_pkg.sv */
// constants and types shared by the 4-bit synchronous binary counter block
package scb_pkg;

  // counter width and state values
  localparam int               CNT_W    = 4;
  localparam logic [CNT_W-1:0] CNT_RST  = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONES = 4'hf;

  // clear build selection
  typedef enum logic [0:0] {
    SCB_CLR_ASYNC = 1'b0,
    SCB_CLR_SYNC  = 1'b1
  } scb_clr_mode_t;

  // bus geometry
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int WB_SW = 4;

  // register byte offsets
  localparam logic [WB_AW-1:0] REG_STATUS = 8'h00;
  localparam logic [WB_AW-1:0] REG_PRESET = 8'h04;

  // status field positions
  localparam int ST_COUNT  = 0;
  localparam int ST_TERM   = 4;
  localparam int ST_EN_PAR = 5;
  localparam int ST_EN_TRK = 6;
  localparam int ST_LOAD_N = 7;
  localparam int ST_CLR_N  = 8;
  localparam int ST_MODE   = 9;
  localparam int ST_W      = 10;

  // reset values
  localparam logic [WB_DW-1:0] WB_DAT_RST = 32'h0000_0000;
  localparam logic [ST_W-1:0]  ST_RST     = 10'h000;

endpackage

/* File: src/scb_carry.sv */
// look-ahead toggle terms for a binary up-counter
`timescale 1ns/1ns
module scb_carry #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] q_i,        // present state
  input  wire logic         en_i,       // both count enables high
  output logic      [W-1:0] toggle_o,   // bits that flip at the edge
  output logic              all_ones_o  // state is all ones
);

  // each bit sees every lower bit at once, so no ripple through stages
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      if (i == 0) begin : g_lsb
        assign toggle_o[i] = en_i;
      end else begin : g_up
        assign toggle_o[i] = en_i & (&q_i[i-1:0]);
      end
    end
  endgenerate

  // terminal state decode
  assign all_ones_o = &q_i;

endmodule

/* File: src/scb_wb.sv */
// classic wishbone slave: registered ack and read data, write strobe on the ack cycle
`timescale 1ns/1ns
module scb_wb (
  input  wire logic                      clk_i,     // system clock
  input  wire logic                      rst_i,     // sync reset, high
  input  wire logic                      wb_cyc_i,  // bus cycle
  input  wire logic                      wb_stb_i,  // strobe
  input  wire logic                      wb_we_i,   // write
  input  wire logic [scb_pkg::WB_DW-1:0] rd_data_i, // decoded read value
  output logic                           wb_ack_o,  // acknowledge
  output logic      [scb_pkg::WB_DW-1:0] wb_dat_o,  // read data
  output logic                           wr_o       // write takes effect now
);
  import scb_pkg::*;

  logic req;

  // one answer per request; ack drops the cycle after it was given
  assign req = wb_cyc_i & wb_stb_i;

  // ack and read data are registered together, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= WB_DAT_RST;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= (req & ~wb_ack_o & ~wb_we_i) ? rd_data_i : WB_DAT_RST;
    end
  end

  // write lands on the edge where the master sees ack high
  assign wr_o = req & wb_we_i & wb_ack_o;

endmodule

/* File: src/scb_counter.sv */
// 4-bit synchronous binary counter with preset, two enables and terminal count
`timescale 1ns/1ns
module scb_counter #(
  parameter scb_pkg::scb_clr_mode_t CLEAR_MODE = scb_pkg::SCB_CLR_ASYNC // clear build
) (
  input  wire logic                      clk_i,                   // counter clock
  input  wire logic                      rst_i,                   // sync reset, high
  input  wire logic                      clear_n_i,               // clear, low
  input  wire logic                      parallel_load_n_i,       // load, low
  input  wire logic                      count_enable_parallel_i, // enable, high
  input  wire logic                      count_enable_trickle_i,  // enable, high
  input  wire logic [scb_pkg::CNT_W-1:0] preset_data_in_i,        // preset data
  output logic      [scb_pkg::CNT_W-1:0] count_value_out_o,       // state
  output logic                           count_lsb_out_o,         // state bit 0
  output logic                           terminal_count_out_o,    // terminal count
  input  wire logic                      wb_cyc_i,                // bus cycle
  input  wire logic                      wb_stb_i,                // strobe
  input  wire logic                      wb_we_i,                 // write
  input  wire logic [scb_pkg::WB_AW-1:0] wb_adr_i,                // byte address
  input  wire logic [scb_pkg::WB_SW-1:0] wb_sel_i,                // byte lanes
  input  wire logic [scb_pkg::WB_DW-1:0] wb_dat_i,                // write data
  output logic      [scb_pkg::WB_DW-1:0] wb_dat_o,                // read data
  output logic                           wb_ack_o                 // acknowledge
);
  import scb_pkg::*;

  // state and helpers
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] toggle;
  logic             all_ones;
  logic             count_en;
  logic [CNT_W-1:0] sw_data;
  logic             sw_load;
  logic [ST_W-1:0]  status;
  logic [WB_DW-1:0] rd_data;
  logic             wr;
  logic             preset_hit;

  // -------------------------------------------------------------
  // counting datapath
  // -------------------------------------------------------------

  // both enables must be high to count
  assign count_en = count_enable_parallel_i & count_enable_trickle_i;

  // look-ahead toggle terms, every bit decided in the same cycle
  scb_carry #(
    .W (CNT_W)
  ) u_carry (
    .q_i        (count),
    .en_i       (count_en),
    .toggle_o   (toggle),
    .all_ones_o (all_ones)
  );

  // next state: pin load beats software preset beats counting
  always_comb begin
    next_count = count;
    if (!parallel_load_n_i) begin
      next_count = preset_data_in_i;
    end else if (sw_load) begin
      next_count = sw_data;
    end else begin
      next_count = count ^ toggle;
    end
  end

  // state flops, one clear style per build
  generate
    if (CLEAR_MODE == SCB_CLR_ASYNC) begin : g_async
      // clear acts without the clock; the recovery is the user's concern
      always_ff @(posedge clk_i or negedge clear_n_i) begin
        if (!clear_n_i) begin
          count <= CNT_RST;
        end else if (rst_i) begin
          count <= CNT_RST;
        end else begin
          count <= next_count;
        end
      end
    end else begin : g_sync
      // clear sampled at the edge, so it outranks load and count
      always_ff @(posedge clk_i) begin
        if (rst_i || !clear_n_i) begin
          count <= CNT_RST;
        end else begin
          count <= next_count;
        end
      end
    end
  endgenerate

  // state straight from the flops
  assign count_value_out_o = count;
  assign count_lsb_out_o   = count[0];

  // terminal count must follow the trickle enable without a clock, so it
  // is the one output that is not a flop; it may spike, never clock with it
  assign terminal_count_out_o = count_enable_trickle_i & all_ones;

  // -------------------------------------------------------------
  // register access
  // -------------------------------------------------------------

  scb_wb u_wb (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .rd_data_i (rd_data),
    .wb_ack_o  (wb_ack_o),
    .wb_dat_o  (wb_dat_o),
    .wr_o      (wr)
  );

  // only the low byte lane carries the preset value
  assign preset_hit = wr & (wb_adr_i == REG_PRESET) & wb_sel_i[0];

  // preset value kept for read-back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_data <= CNT_RST;
    end else if (preset_hit) begin
      sw_data <= wb_dat_i[CNT_W-1:0];
    end
  end

  // one-cycle software load request; a clear in that cycle swallows it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_load <= 1'b0;
    end else begin
      sw_load <= preset_hit;
    end
  end

  // pin and state snapshot, one cycle old when read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= ST_RST;
    end else begin
      status[ST_COUNT +: CNT_W] <= count;
      status[ST_TERM]           <= terminal_count_out_o;
      status[ST_EN_PAR]         <= count_enable_parallel_i;
      status[ST_EN_TRK]         <= count_enable_trickle_i;
      status[ST_LOAD_N]         <= parallel_load_n_i;
      status[ST_CLR_N]          <= clear_n_i;
      status[ST_MODE]           <= CLEAR_MODE;
    end
  end

  // read decode; unmapped words read as zero
  always_comb begin
    rd_data = WB_DAT_RST;
    unique case (wb_adr_i)
      REG_STATUS: rd_data[ST_W-1:0]  = status;
      REG_PRESET: rd_data[CNT_W-1:0] = sw_data;
      default:    rd_data = WB_DAT_RST;
    endcase
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (rst_i);

  // an edge with no clear, no load and no software preset
  sequence s_free_edge;
    clear_n_i && parallel_load_n_i && !sw_load;
  endsequence

  // a bus write to the preset word as it lands
  sequence s_preset_write;
    wr && wb_adr_i == REG_PRESET && wb_sel_i[0];
  endsequence

  // the clear held into the following edge
  sequence s_clear_kept;
    ##1 clear_n_i;
  endsequence

  // load copies the data whatever the enables hold
  property p_load;
    (clear_n_i && !parallel_load_n_i) ##0 s_clear_kept
      |-> count == $past(preset_data_in_i);
  endproperty
  a_load: assert property (p_load)
    else $error("load did not copy preset data");

  // both enables high advance the state by exactly one
  property p_count;
    (s_free_edge and count_en) ##0 s_clear_kept
      |-> count == CNT_W'($past(count) + CNT_W'(1));
  endproperty
  a_count: assert property (p_count)
    else $error("enabled edge did not add one");

  // either enable low keeps the state
  property p_hold;
    (s_free_edge and !count_en) ##0 s_clear_kept
      |-> $stable(count);
  endproperty
  a_hold: assert property (p_hold)
    else $error("state moved with an enable low");

  // all ones wraps to zero on a count
  property p_wrap;
    (s_free_edge and count_en and count == CNT_ONES) ##0 s_clear_kept
      |-> count == CNT_RST;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("all ones did not wrap to zero");

  // terminal count high means trickle high and all ones
  property p_term_cause;
    terminal_count_out_o |-> count_enable_trickle_i && count == CNT_ONES;
  endproperty
  a_term_cause: assert property (p_term_cause)
    else $error("terminal count high without its cause");

  // terminal count rides inside the lsb high time while counting
  property p_term_pulse;
    (terminal_count_out_o and s_free_edge and count_en) ##0 s_clear_kept
      |-> !terminal_count_out_o && !count_lsb_out_o;
  endproperty
  a_term_pulse: assert property (p_term_pulse)
    else $error("terminal count pulse outlived the lsb");

  // a bus preset reaches the state one edge after it lands
  property p_sw_load;
    (s_preset_write and parallel_load_n_i) ##1 (clear_n_i && parallel_load_n_i)
      ##0 s_clear_kept |-> count == $past(wb_dat_i[CNT_W-1:0], 2);
  endproperty
  a_sw_load: assert property (p_sw_load)
    else $error("bus preset not applied");

  // the bus answers in one cycle and drops ack the cycle after
  property p_ack;
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not a one-cycle answer");

  // a request not yet answered, as the slave takes it
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  // ack only answers a request that stood at the edge before
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");

  // read data stays zero outside the ack cycle, so a late sample sees nothing stale
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == WB_DAT_RST;
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside the ack cycle");

  // preset read returns the stored value, upper bits zero
  property p_rd_preset;
    (s_bus_req ##0 (!wb_we_i && wb_adr_i == REG_PRESET))
      |=> wb_dat_o == WB_DW'($past(sw_data));
  endproperty
  a_rd_preset: assert property (p_rd_preset)
    else $error("preset read-back wrong");

  // status read returns the snapshot standing at the request edge
  property p_rd_status;
    (s_bus_req ##0 (!wb_we_i && wb_adr_i == REG_STATUS))
      |=> wb_dat_o == WB_DW'($past(status));
  endproperty
  a_rd_status: assert property (p_rd_status)
    else $error("status read wrong");

  // unmapped words read as zero
  property p_rd_unmapped;
    (s_bus_req ##0 (!wb_we_i && wb_adr_i != REG_STATUS && wb_adr_i != REG_PRESET))
      |=> wb_dat_o == WB_DAT_RST;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");

  // a landed preset write stores the low data bits
  property p_sw_data;
    s_preset_write |=> sw_data == $past(wb_dat_i[CNT_W-1:0]);
  endproperty
  a_sw_data: assert property (p_sw_data)
    else $error("preset write not stored");

  // other writes, or the preset lane off, leave the preset alone
  property p_bad_write;
    (wr && !(wb_adr_i == REG_PRESET && wb_sel_i[0]))
      |=> $stable(sw_data) && !sw_load;
  endproperty
  a_bad_write: assert property (p_bad_write)
    else $error("ignored write touched the preset");

  // the software load request lasts one cycle, so it never reloads twice
  property p_sw_once;
    sw_load |=> !sw_load;
  endproperty
  a_sw_once: assert property (p_sw_once)
    else $error("software load held too long");

  // a pending bus preset beats counting when no pin load or clear is present
  property p_sw_over_count;
    (sw_load && clear_n_i && parallel_load_n_i) ##0 s_clear_kept
      |-> count == $past(sw_data);
  endproperty
  a_sw_over_count: assert property (p_sw_over_count)
    else $error("bus preset lost to counting");

  // trickle low keeps terminal count low without waiting for an edge
  property p_term_trickle;
    !count_enable_trickle_i |-> !terminal_count_out_o;
  endproperty
  a_term_trickle: assert property (p_term_trickle)
    else $error("terminal count high with trickle low");

  generate
    if (CLEAR_MODE == SCB_CLR_ASYNC) begin : g_chk_async
      // clear low shows zero state and low terminal count at every edge
      property p_async_clear;
        !clear_n_i |-> count == CNT_RST && !terminal_count_out_o;
      endproperty
      a_async_clear: assert property (p_async_clear)
        else $error("async clear did not zero the counter");
    end else begin : g_chk_sync
      // clear at an edge zeroes the state whatever load or enables do
      property p_sync_clear;
        !clear_n_i |=> count == CNT_RST;
      endproperty
      a_sync_clear: assert property (p_sync_clear)
        else $error("sync clear did not zero the counter");

      // the clear waits for the edge: state before it is untouched
      property p_sync_wait;
        (clear_n_i && parallel_load_n_i && !sw_load && !count_en)
          ##1 !clear_n_i |-> $stable(count);
      endproperty
      a_sync_wait: assert property (p_sync_wait)
        else $error("sync clear acted before the edge");
    end
  endgenerate

endmodule

/* File: sim/scb_far_logic.sv */
// surrounding logic: next cascaded stage and state decode into sync clear
`timescale 1ns/1ns
module scb_far_logic #(
  parameter logic [3:0] DECODE_AT = 4'h6 // state that ends the shortened cycle
) (
  input  wire logic       clk_i,     // shared clock
  input  wire logic       rst_i,     // sync reset, high
  input  wire logic       carry_i,   // terminal count of the lower stage
  input  wire logic       en_par_i,  // parallel enable shared by stages
  input  wire logic [3:0] state_i,   // state of the sync build stage
  output logic            clear_n_o, // decoded sync clear, low
  output logic      [3:0] upper_o    // next stage value
);
  // next stage on the same clock; terminal count only enables, never clocks, as it may spike
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upper_o <= 4'h0;
    end else if (carry_i && en_par_i) begin
      upper_o <= upper_o + 4'h1;
    end
  end

  // single nand decode fed back to the sync clear
  assign clear_n_o = ~(state_i == DECODE_AT);
endmodule

/* File: sim/sync_binary_counter_4bit_bench.sv */
// bench for the 4-bit counter: both clear builds, bus access and far logic
`timescale 1ns/1ns
module sync_binary_counter_4bit_bench;
  import scb_pkg::*;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        clr_n    = 1'b1;
  logic        load_n   = 1'b1;
  logic        en_par   = 1'b0;
  logic        en_trk   = 1'b0;
  logic [3:0]  pdata    = 4'h0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic        wb_ack_o;
  logic        term_a;
  logic        term_s;
  logic        lsb_a;
  logic        far_clr_n;
  logic        clr_s;
  logic [3:0]  q_a;
  logic [3:0]  q_s;
  logic [3:0]  upper;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  assign clr_s = clr_n & far_clr_n;

  // async build carries the bus; sync build shares the pins except clear, which is clr_n anded with the far decode
  scb_counter u_scb_counter (
    .clk_i, .rst_i, .clear_n_i(clr_n), .parallel_load_n_i(load_n),
    .count_enable_parallel_i(en_par), .count_enable_trickle_i(en_trk),
    .preset_data_in_i(pdata), .count_value_out_o(q_a), .count_lsb_out_o(lsb_a),
    .terminal_count_out_o(term_a), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  scb_counter #(.CLEAR_MODE(SCB_CLR_SYNC)) u_scb_counter_sync (
    .clk_i, .rst_i, .clear_n_i(clr_s), .parallel_load_n_i(load_n),
    .count_enable_parallel_i(en_par), .count_enable_trickle_i(en_trk),
    .preset_data_in_i(pdata), .count_value_out_o(q_s), .count_lsb_out_o(),
    .terminal_count_out_o(term_s), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o(), .wb_ack_o());
  scb_far_logic u_scb_far_logic (
    .clk_i, .rst_i, .carry_i(term_a), .en_par_i(en_par), .state_i(q_s),
    .clear_n_o(far_clr_n), .upper_o(upper));

  always #5 clk_i = ~clk_i;

  // hang guard, far above the 43 cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 1000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  // new pin levels at an edge; results of the old levels are then settled
  task automatic set(input logic ld, input logic p, input logic t, input logic [3:0] d);
    @(posedge clk_i);
    load_n <= ld;
    en_par <= p;
    en_trk <= t;
    pdata <= d;
    #1;
  endtask

  // classic single cycle, held until ack is sampled at an edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    check(n, 2); // request edge, then ack sampled one edge later
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    set(1'b0, 1'b0, 1'b0, 4'h9);
    check(q_a, 4'h0);
    set(1'b0, 1'b1, 1'b1, 4'he);
    check(q_a, 4'h9);
    check(q_s, 4'h9);
    set(1'b1, 1'b1, 1'b1, 4'he);
    check(q_a, 4'he);
    set(1'b1, 1'b1, 1'b0, 4'he);
    check(q_a, 4'hf);
    check(term_a, 1'b0);
    set(1'b1, 1'b1, 1'b1, 4'he);
    check(q_a, 4'hf);
    check(term_a, 1'b1);
    check(upper, 4'h0);
    set(1'b1, 1'b0, 1'b0, 4'he);
    check(q_a, 4'h0);
    check(q_s, 4'h0);
    check(upper, 4'h1);
    // clear while load is also low: async acts at once, sync waits for the edge
    set(1'b0, 1'b0, 1'b1, 4'hf);
    set(1'b1, 1'b0, 1'b1, 4'hf);
    check(term_s, 1'b1);
    @(posedge clk_i);
    clr_n <= 1'b0;
    load_n <= 1'b0;
    #1;
    check(q_a, 4'h0);
    check(term_a, 1'b0);
    check(q_s, 4'hf);
    set(1'b0, 1'b1, 1'b1, 4'hf);
    check(q_s, 4'h0);
    check(q_a, 4'h0);
    @(posedge clk_i);
    clr_n <= 1'b1;
    load_n <= 1'b1;
    en_par <= 1'b0;
    // bus preset, readback, unmapped place, lane off and status
    wb_xfer(1'b1, REG_PRESET, 32'h0000_0003);
    @(posedge clk_i);
    #1;
    check(q_a, 4'h3);
    wb_xfer(1'b0, REG_PRESET, 32'h0000_0000);
    check(rd, 32'h0000_0003);
    wb_xfer(1'b0, 8'h20, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    wb_sel_i <= 4'he;
    wb_xfer(1'b1, REG_PRESET, 32'h0000_0005);
    wb_sel_i <= 4'hf;
    wb_xfer(1'b0, REG_PRESET, 32'h0000_0000);
    check(rd, 32'h0000_0003);
    // status: state 3, trickle, load and clear high, async build
    wb_xfer(1'b0, REG_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_01c3);
    // shortened cycle: decode of 6 clears the sync build
    set(1'b0, 1'b0, 1'b0, 4'h0);
    set(1'b1, 1'b1, 1'b1, 4'h0);
    repeat (7) @(posedge clk_i);
    #1;
    check(q_s, 4'h0);
    check(q_a, 4'h7);
    check(lsb_a, 1'b1);
    tally_and_finish();
  end
endmodule
